// *** shared/drc_regs.svh ***
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH
// Sixth mode register field positions
`define DRC_ENA_BIT 7
`define DRC_RANGE_BIT 6
`define DRC_CODE_MSB 5
`define DRC_MR_SEL 3'h6
// Highest programmable level code, above it reserved
`define DRC_CODE_MAX 6'h32
// Timing, in ns, and derived cycle counts at 40 MHz
`define DRC_CLK_MHZ 40
`define DRC_ENTRY_NS 150
`define DRC_EXIT_NS 150
`define DRC_SETTLE_LONG_NS 150
`define DRC_CYC(ns) (((ns) * `DRC_CLK_MHZ + 999) / 1000)
`define DRC_CNT_W 4
`endif

// *** shared/drc_pkg.sv ***
`default_nettype none
package drc_pkg;
  // One decoded command from the controller
  typedef struct packed {
    logic mrs;
    logic [2:0] mr_sel;
    logic [7:0] addr;
    logic dq0;
  } drc_cmd_t;
  // Mode state, one-hot
  typedef enum logic [3:0] {
    DRC_IDLE = 4'h1,
    DRC_ENTER = 4'h2,
    DRC_CAL = 4'h4,
    DRC_EXIT = 4'h8
  } drc_state_t;
  // Stored reference setting
  typedef struct packed {
    logic range;
    logic [5:0] code;
  } drc_level_t;
endpackage
`default_nettype wire

// *** rtl/drc_wait_cnt.sv ***
`default_nettype none
`include "drc_regs.svh"
// Down-counter: load, then done when it reaches zero
module drc_wait_cnt (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic load_i,
  input wire logic [`DRC_CNT_W-1:0] count_i,
  output logic done_o
);
  logic [`DRC_CNT_W-1:0] cnt_r;
  logic [`DRC_CNT_W-1:0] cnt_nxt;
  // Next count
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = count_i;
    end else if (cnt_r != 4'h0) begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end
  // Register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign done_o = (cnt_r == 4'h0);
endmodule
`default_nettype wire

// *** rtl/drc_cal_mode.sv ***
`default_nettype none
`include "drc_regs.svh"
module drc_cal_mode
  import drc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire drc_cmd_t cmd_i,
  input wire logic per_device_select_mode_i,
  output logic cal_active_o,
  output logic cmd_ready_o,
  output logic [6:0] data_input_reference_o,
  output logic level_valid_o,
  output logic reserved_err_o,
  output logic range_err_o
);
  localparam logic [`DRC_CNT_W-1:0] ENTRY_CYC = `DRC_CNT_W'(`DRC_CYC(`DRC_ENTRY_NS));
  localparam logic [`DRC_CNT_W-1:0] EXIT_CYC = `DRC_CNT_W'(`DRC_CYC(`DRC_EXIT_NS));
  localparam logic [`DRC_CNT_W-1:0] SETTLE_CYC =
    `DRC_CNT_W'(`DRC_CYC(`DRC_SETTLE_LONG_NS));

  drc_state_t state_r, state_nxt;
  drc_level_t level_r, level_nxt;
  logic range_lat_r, range_lat_nxt;
  logic active_r, active_nxt;
  logic ready_r, ready_nxt;
  logic valid_r, valid_nxt;
  logic rsv_r, rsv_nxt;
  logic rerr_r, rerr_nxt;
  logic load_wait;
  logic [`DRC_CNT_W-1:0] wait_val;
  logic wait_done;
  logic settle_load;
  logic settle_done;
  logic sixth_wr;
  logic en_bit;

  // Register write to the sixth register, gated by dq0 in per-device mode
  assign sixth_wr = cmd_i.mrs && (cmd_i.mr_sel == `DRC_MR_SEL) &&
                    !(per_device_select_mode_i && cmd_i.dq0);
  assign en_bit = cmd_i.addr[`DRC_ENA_BIT];

  // Entry/exit delay timer
  drc_wait_cnt u_wait (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .load_i(load_wait),
    .count_i(wait_val),
    .done_o(wait_done)
  );
  // Level settling timer, worst-case budget for any step size
  drc_wait_cnt u_settle (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .load_i(settle_load),
    .count_i(SETTLE_CYC),
    .done_o(settle_done)
  );

  // Mode sequencing and reference storage
  always_comb begin
    state_nxt = state_r;
    level_nxt = level_r;
    range_lat_nxt = range_lat_r;
    active_nxt = active_r;
    rsv_nxt = 1'b0;
    rerr_nxt = 1'b0;
    load_wait = 1'b0;
    wait_val = ENTRY_CYC;
    settle_load = 1'b0;
    case (state_r)
      DRC_IDLE: begin
        if (sixth_wr && en_bit) begin
          state_nxt = DRC_ENTER;
          range_lat_nxt = cmd_i.addr[`DRC_RANGE_BIT];
          level_nxt.range = cmd_i.addr[`DRC_RANGE_BIT];
          active_nxt = 1'b1;
          load_wait = 1'b1;
        end
      end
      DRC_ENTER: begin
        // Commands not expected until entry delay runs out
        if (wait_done) begin
          state_nxt = DRC_CAL;
        end
      end
      DRC_CAL: begin
        if (sixth_wr && en_bit) begin
          // Level load; flag misuse but still store as written
          level_nxt.range = cmd_i.addr[`DRC_RANGE_BIT];
          level_nxt.code = cmd_i.addr[`DRC_CODE_MSB:0];
          settle_load = 1'b1;
          rsv_nxt = (cmd_i.addr[`DRC_CODE_MSB:0] > `DRC_CODE_MAX);
          rerr_nxt = (cmd_i.addr[`DRC_RANGE_BIT] != range_lat_r);
        end else if (sixth_wr) begin
          // Exit keeps last setting; bits 6:0 not written
          state_nxt = DRC_EXIT;
          active_nxt = 1'b0;
          load_wait = 1'b1;
          wait_val = EXIT_CYC;
        end
      end
      DRC_EXIT: begin
        if (wait_done) begin
          state_nxt = DRC_IDLE;
        end
      end
      default: begin
        state_nxt = DRC_IDLE;
        active_nxt = 1'b0;
      end
    endcase
    // Ready only once the pending delay has elapsed
    // Registered, so ready lags the counter by an edge: errs on the safe side
    ready_nxt = (state_nxt == DRC_IDLE || state_nxt == DRC_CAL) && !load_wait &&
                !(state_r == DRC_ENTER || state_r == DRC_EXIT) || (wait_done &&
                (state_r == DRC_ENTER || state_r == DRC_EXIT));
    valid_nxt = settle_done && !settle_load && !load_wait;
  end

  // Registers only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_r <= DRC_IDLE;
      level_r <= 7'h00;
      range_lat_r <= 1'b0;
      active_r <= 1'b0;
      ready_r <= 1'b0;
      valid_r <= 1'b0;
      rsv_r <= 1'b0;
      rerr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      level_r <= level_nxt;
      range_lat_r <= range_lat_nxt;
      active_r <= active_nxt;
      ready_r <= ready_nxt;
      valid_r <= valid_nxt;
      rsv_r <= rsv_nxt;
      rerr_r <= rerr_nxt;
    end
  end

  assign cal_active_o = active_r;
  assign cmd_ready_o = ready_r;
  assign data_input_reference_o = level_r;
  assign level_valid_o = valid_r;
  assign reserved_err_o = rsv_r;
  assign range_err_o = rerr_r;

  // Entry: mode taken, ready low through the whole entry delay
  AST_ENTRY: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == DRC_IDLE && sixth_wr && en_bit) |=> cal_active_o && state_r == DRC_ENTER)
    else $error("entry not taken");
  AST_ENTRY_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == DRC_IDLE && sixth_wr && en_bit) |=> !cmd_ready_o [*7] ##1 cmd_ready_o)
    else $error("ready before entry delay");

  // Level writes: load, settling, flags
  AST_LOAD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == DRC_CAL && sixth_wr && en_bit) |=>
      data_input_reference_o == $past(cmd_i.addr[6:0]))
    else $error("level not loaded");
  AST_SETTLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == DRC_CAL && sixth_wr && en_bit) |=> !level_valid_o [*6])
    else $error("level valid before settling");
  AST_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (sixth_wr && !en_bit) |=> $stable(data_input_reference_o))
    else $error("bits changed on disabled write");
  AST_RSV: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == DRC_CAL && sixth_wr && en_bit && cmd_i.addr[5:0] > `DRC_CODE_MAX) |=>
      reserved_err_o)
    else $error("reserved code not flagged");
  // Error pulses only ever follow a level write
  AST_ERR_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !(state_r == DRC_CAL && sixth_wr && en_bit) |=> !reserved_err_o && !range_err_o)
    else $error("error flag without level write");
  AST_RANGE_ERR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == DRC_CAL && sixth_wr && en_bit) |=>
      range_err_o == ($past(cmd_i.addr[`DRC_RANGE_BIT]) != $past(range_lat_r)))
    else $error("range change flag wrong");
  AST_RANGE_LATCH: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (cal_active_o && $past(cal_active_o)) |-> $stable(range_lat_r))
    else $error("latched range moved");

  // Exit: setting kept, ready low through the exit delay
  AST_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $fell(cal_active_o) |-> $stable(data_input_reference_o))
    else $error("exit altered setting");
  AST_EXIT_WAIT: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $fell(cal_active_o) |-> !cmd_ready_o [*7] ##1 cmd_ready_o)
    else $error("exit delay wrong");

  // Per-device mode: dq0 high leaves mode and setting alone
  AST_PER_DEV: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (per_device_select_mode_i && cmd_i.dq0 && (state_r == DRC_IDLE || state_r == DRC_CAL))
      |=> $stable(state_r) && $stable(data_input_reference_o))
    else $error("command executed with dq0 high");

  // Main scenarios
  COV_ENTRY: cover property (@(posedge clk_sys_i) $rose(cal_active_o));
  COV_LOAD: cover property (@(posedge clk_sys_i) state_r == DRC_CAL && sixth_wr && en_bit);
  COV_EXIT: cover property (@(posedge clk_sys_i) $fell(cal_active_o));
  COV_PER_DEV_SKIP: cover property (@(posedge clk_sys_i)
    per_device_select_mode_i && cmd_i.mrs && cmd_i.dq0);
  COV_RESERVED: cover property (@(posedge clk_sys_i) reserved_err_o);
endmodule
`default_nettype wire

// *** dv/drc_ctl_model.sv ***
`default_nettype none
// Controller side: sends register writes, keeps entry, exit and settling waits
module drc_ctl_model
  import drc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic cmd_ready_i,
  input wire logic level_valid_i,
  output drc_cmd_t cmd_o,
  output logic pdm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus at time zero
  initial begin
    cmd_o = '0;
    pdm_o = 1'b0;
  end
  // One command for one edge; released lines flip so stale values never match
  task automatic send(input logic [2:0] sel, input logic [7:0] a, input logic d, input logic p);
    @(posedge clk_sys_i);
    #1;
    cmd_o = '{mrs: 1'b1, mr_sel: sel, addr: a, dq0: d};
    pdm_o = p;
    @(posedge clk_sys_i);
    #1;
    cmd_o = '{mrs: 1'b0, mr_sel: ~sel, addr: ~a, dq0: ~d};
  endtask
  // Non-register command cycle (write, read, activate): must load nothing
  task automatic other_cmd(input logic [7:0] a);
    @(posedge clk_sys_i);
    #1;
    cmd_o = '{mrs: 1'b0, mr_sel: 3'h6, addr: a, dq0: 1'b0};
    @(posedge clk_sys_i);
    #1;
    cmd_o = '{mrs: 1'b0, mr_sel: 3'h1, addr: ~a, dq0: 1'b1};
  endtask
  // Deselects only until the delay, and settling if asked, has passed
  task automatic wait_ready(input bit v, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(posedge clk_sys_i);
      #1;
      ok = (cmd_ready_i === 1'b1) && (!v || level_valid_i === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drc_pkg::*;
  logic clk_sys_i, rst_b_i, act, rdy, vld, res_err, rng_err, pdm;
  logic [6:0] dref;
  drc_cmd_t cmd;
  int mismatches, compares, rng, lvl;
  int codes[$] = '{0, 50, 51, 63, 1, 0};
  bit ok;
  drc_cal_mode i_drc_cal_mode(.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cmd_i(cmd),
    .per_device_select_mode_i(pdm), .cal_active_o(act), .cmd_ready_o(rdy),
    .data_input_reference_o(dref), .level_valid_o(vld), .reserved_err_o(res_err),
    .range_err_o(rng_err));
  drc_ctl_model i_drc_ctl_model(.clk_sys_i(clk_sys_i), .cmd_ready_i(rdy),
    .level_valid_i(vld), .cmd_o(cmd), .pdm_o(pdm));
  // 40 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait; a hang ends the run
  task automatic ready(input bit v);
    i_drc_ctl_model.wait_ready(v, ok);
    if (!ok) begin
      mismatches++;
      $display("BAD %0t no ready", $time);
      print_verdict();
    end
  endtask
  // Level write; reserved codes are stored as written but not checked
  task automatic lvl_wr(input int c, input int r, input bit d, input bit p);
    bit taken;
    taken = !(p && d);
    i_drc_ctl_model.send(3'h6, {1'b1, r[0], c[5:0]}, d, p);
    chk({res_err, rng_err}, {taken && c > 50, taken && r != rng});
    if (taken) begin
      chk(vld, 0);
    end
    if (taken && c <= 50) begin
      lvl = {r[0], c[5:0]};
    end
    if (c <= 50) begin
      chk(dref, lvl);
    end
  endtask
  // Main sequence
  initial begin
    void'($urandom(8211));
    rst_b_i = 1'b0;
    mismatches = 0;
    compares = 0;
    lvl = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    chk({act, rdy, vld, res_err, rng_err, dref}, 0);
    i_drc_ctl_model.send(3'h6, 8'h5F, 0, 0);
    chk({act, dref}, 0);
    rng = $urandom_range(1, 0);
    i_drc_ctl_model.send(3'h6, {1'b1, rng[0], 6'h3F}, 0, 0);
    chk({act, rdy}, 2'h2);
    ready(0);
    // Dummy writes before the first level; mrs low so nothing may load
    repeat (3) i_drc_ctl_model.other_cmd(8'($urandom_range(255, 0)));
    chk({act, rdy, dref[6]}, {2'h3, rng[0]});
    codes[5] = $urandom_range(50, 0);
    foreach (codes[i]) lvl_wr(codes[i], rng, 0, 0);
    i_drc_ctl_model.other_cmd(8'hC5);
    chk({act, rdy, dref}, {2'h3, lvl[6:0]});
    lvl_wr($urandom_range(50, 0), rng, 1, 1);
    lvl_wr($urandom_range(50, 0), rng, 0, 1);
    lvl_wr($urandom_range(50, 0), 1 - rng, 0, 0);
    lvl_wr($urandom_range(50, 0), rng, 0, 0);
    ready(1);
    // Exit repeats the stored setting: no new level, no range change
    i_drc_ctl_model.send(3'h6, {1'b0, lvl[6:0]}, 0, 0);
    chk({act, rdy, dref}, {2'h0, lvl[6:0]});
    ready(0);
    // Reset during the entry delay drops the mode and the stored setting
    i_drc_ctl_model.send(3'h6, {1'b1, rng[0], 6'h00}, 0, 0);
    chk(act, 1);
    rst_b_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    chk({act, rdy, vld, res_err, rng_err, dref}, 0);
    ready(0);
    print_verdict();
  end
endmodule
`default_nettype wire
